// File: logic/sleep_wake_cfg.svh
// constants for the sleep and wake controller
`ifndef SLEEP_WAKE_CFG_SVH
`define SLEEP_WAKE_CFG_SVH
`define CLK_MHZ 40
`define WDT_PERIOD_US 17000
`define OST_OSC_PERIODS 1024
`define OSC_PER_CLK 1
`define IO_PINS 8
`define IRQ_SRCS 7
`define IRQ_VECTOR 13'h0004
`define PC_W 13
`define ADDR_W 4
`define DATA_W 8
`define REG_CTRL 4'h0
`define REG_IRQ_EN 4'h1
`define REG_STATUS 4'h2
`define CTRL_WDT_EN 0
`define CTRL_GIE 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 4
`define CTRL_RESET 8'h00
`define IRQ_EN_RESET 8'h00
`define ST_PD 0
`define ST_TO 1
`define ST_STATE_LO 2
`define ST_STATE_HI 3
`define ST_CAUSE_LO 4
`define ST_CAUSE_HI 6
`define IRQ_TIMER1 0
`define IRQ_CAPTURE 1
`define IRQ_ADC_RC 2
`define IRQ_NVM_WRITE 3
`define IRQ_COMPARATOR 4
`define IRQ_PORT_CHANGE 5
`define IRQ_EXT_PIN 6
`endif

// File: logic/sleep_wake_pkg.sv
// types for the sleep and wake controller
`include "sleep_wake_cfg.svh"
package sleep_wake_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OST = 2'b10
  } pwr_state_t;
  typedef enum logic [2:0] {
    crystal_mode_low_power = 3'b000,
    crystal_mode_medium = 3'b001,
    crystal_mode_high_speed = 3'b010,
    external_clock_mode = 3'b011,
    internal_osc_mode = 3'b100,
    rc_osc_mode = 3'b101
  } osc_mode_t;
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_MASTER_CLEAR_PIN = 3'b001,
    CAUSE_WDT = 3'b010,
    CAUSE_IRQ = 3'b011
  } wake_cause_t;
  typedef struct packed {
    logic [`IO_PINS-1:0] level;
    logic [`IO_PINS-1:0] oe_n;
  } io_drive_t;
endpackage

// File: logic/sleep_wake_controller.sv
// power-down controller: sleep entry, watchdog, wake and resume
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "sleep_wake_cfg.svh"
module sleep_wake_controller
  import sleep_wake_pkg::*;
#(
  parameter int WDT_CYCLES = `WDT_PERIOD_US * `CLK_MHZ,
  parameter int WDT_W = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DATA_W-1:0] rdata_o,
  input wire logic sleep_exec_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic [`PC_W-1:0] pc_i,
  input wire logic [`IRQ_SRCS-1:0] irq_flags_i,
  input wire logic master_clear_pin_n_i,
  output logic master_clear_pin_oe_n_o,
  input wire io_drive_t io_i,
  output io_drive_t io_o,
  output logic osc_en_o,
  output logic core_reset_o,
  output logic resume_o,
  output logic vector_o,
  output logic sleep_nop_o,
  output logic [`PC_W-1:0] prefetch_addr_o,
  output logic [`PC_W-1:0] vector_addr_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o
);
  localparam int OST_CYCLES = `OST_OSC_PERIODS * `OSC_PER_CLK;
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
  localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

  pwr_state_t state_r, state_nxt;
  wake_cause_t cause_r, cause_nxt;
  logic [`DATA_W-1:0] ctrl_r, irq_en_r, rdata_r;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [10:0] ost_cnt_r;
  logic master_clear_pin_m1_r, master_clear_pin_m2_r;
  logic pd_r, pd_nxt, to_r, to_nxt;
  logic core_reset_r, resume_r, vector_r, nop_r;
  logic [`PC_W-1:0] prefetch_r;
  io_drive_t io_r;

  // decode
  wire wr_ctrl = wr_i && (addr_i == `REG_CTRL);
  wire wr_irq_en = wr_i && (addr_i == `REG_IRQ_EN);
  wire wdt_en = ctrl_r[`CTRL_WDT_EN];
  wire global_irq_enable = ctrl_r[`CTRL_GIE];
  wire osc_mode_t mode = osc_mode_t'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  wire crystal = (mode == crystal_mode_low_power) || (mode == crystal_mode_medium) ||
                 (mode == crystal_mode_high_speed);
  // purely combinational so a sleeping core with no clock still sees it
  wire [`IRQ_SRCS-1:0] wake_src = irq_flags_i & irq_en_r[`IRQ_SRCS-1:0];
  wire wake_req = |wake_src;
  wire master_clear_pin_act = ~master_clear_pin_m2_r;
  wire in_run = (state_r == ST_RUN);
  wire in_sleep = (state_r == ST_SLEEP);
  wire in_ost = (state_r == ST_OST);
  wire sleep_go = in_run && sleep_exec_i && !wake_req;
  wire sleep_nop = in_run && sleep_exec_i && wake_req;
  wire wdt_to = wdt_en && (wdt_cnt_r == WDT_LAST);
  wire wake_wdt = in_sleep && wdt_to && !master_clear_pin_act;
  wire wake_irq = in_sleep && wake_req && !master_clear_pin_act && !wdt_to;
  wire wake_any = wake_wdt || wake_irq;
  wire ost_done = in_ost && (ost_cnt_r == OST_LAST);
  wire do_resume = (wake_any && !crystal) || ost_done;
  wire wdt_reset = in_run && wdt_to && !master_clear_pin_act;
  wire wdt_clr = watchdog_clear_instr_i || sleep_go || wake_any || in_ost || master_clear_pin_act || wdt_reset;
  wire [`DATA_W-1:0] status_word = {1'b0, cause_r, state_r, to_r, pd_r};
  wire [`DATA_W-1:0] rd_mux = (addr_i == `REG_CTRL) ? ctrl_r :
                              (addr_i == `REG_IRQ_EN) ? irq_en_r :
                              (addr_i == `REG_STATUS) ? status_word : '0;

  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    unique case (state_r)
      ST_RUN: begin
        if (sleep_go) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (master_clear_pin_act) begin
          state_nxt = ST_RUN;
          cause_nxt = CAUSE_MASTER_CLEAR_PIN;
        end else if (wake_any) begin
          state_nxt = crystal ? ST_OST : ST_RUN;
          cause_nxt = wake_wdt ? CAUSE_WDT : CAUSE_IRQ;
        end
      end
      ST_OST: begin
        if (master_clear_pin_act) begin
          state_nxt = ST_RUN;
          cause_nxt = CAUSE_MASTER_CLEAR_PIN;
        end else if (ost_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_comb begin
    pd_nxt = pd_r;
    to_nxt = to_r;
    if (sleep_go) begin
      pd_nxt = 1'b0;
      to_nxt = 1'b1;
    end else if (wake_wdt || wdt_reset) begin
      to_nxt = 1'b0;
    end
  end

  // master_clear_pin pin synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_clear_pin_m1_r <= 1'b1;
      master_clear_pin_m2_r <= 1'b1;
    end else if (ce_i) begin
      master_clear_pin_m1_r <= master_clear_pin_n_i;
      master_clear_pin_m2_r <= master_clear_pin_m1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      cause_r <= CAUSE_NONE;
      pd_r <= 1'b1;
      to_r <= 1'b1;
    end else if (ce_i) begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      pd_r <= pd_nxt;
      to_r <= to_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
      irq_en_r <= `IRQ_EN_RESET;
      rdata_r <= '0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_i;
      end
      if (wr_irq_en) begin
        irq_en_r <= wdata_i;
      end
      rdata_r <= rd_i ? rd_mux : '0;
    end
  end

  // watchdog runs on through sleep, since osc_en_o does not gate it; ce_i low stops its count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_cnt_r <= '0;
    end else if (ce_i) begin
      if (wdt_clr || !wdt_en) begin
        wdt_cnt_r <= '0;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_cnt_r <= '0;
    end else if (ce_i) begin
      if (in_ost) begin
        ost_cnt_r <= ost_cnt_r + 11'(1);
      end else begin
        ost_cnt_r <= '0;
      end
    end
  end

  // pins are sampled only while awake, so sleep freezes them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_r <= '{level: '0, oe_n: '1};
      prefetch_r <= '0;
    end else if (ce_i) begin
      if (in_run && !sleep_go) begin
        io_r <= io_i;
      end
      if (in_run && sleep_exec_i) begin
        prefetch_r <= pc_i + `PC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      nop_r <= 1'b0;
    end else if (ce_i) begin
      core_reset_r <= master_clear_pin_act || wdt_reset;
      resume_r <= do_resume && !master_clear_pin_act;
      vector_r <= do_resume && !master_clear_pin_act && global_irq_enable && (cause_nxt == CAUSE_IRQ);
      nop_r <= sleep_nop;
    end
  end

  assign rdata_o = rdata_r;
  assign master_clear_pin_oe_n_o = 1'b1;
  assign io_o = io_r;
  assign osc_en_o = !in_sleep;
  assign core_reset_o = core_reset_r;
  assign resume_o = resume_r;
  assign vector_o = vector_r;
  assign sleep_nop_o = nop_r;
  assign prefetch_addr_o = prefetch_r;
  assign vector_addr_o = `IRQ_VECTOR;
  assign power_down_flag_o = pd_r;
  assign timeout_flag_o = to_r;

  // start-up span counted apart from the design counter, so a wrong end point shows
  localparam logic [11:0] OST_SPAN = 12'(OST_CYCLES);
  logic [11:0] ost_span_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_span_r <= '0;
    end else if (ce_i) begin
      ost_span_r <= in_ost ? ost_span_r + 12'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_i iff ce_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sleep_go;
    in_run && sleep_exec_i && !wake_req;
  endsequence
  sequence s_irq_wake_fast;
    in_sleep && wake_req && master_clear_pin_m2_r && !wdt_to && !crystal;
  endsequence

  property p_enter_sleep;
    s_sleep_go |=> in_sleep && !osc_en_o;
  endproperty
  a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered");

  property p_wdt_entry;
    s_sleep_go |=> wdt_cnt_r == '0;
  endproperty
  a_wdt_entry: assert property (p_wdt_entry) else $error("watchdog not cleared on entry");

  property p_flags_entry;
    s_sleep_go |=> !power_down_flag_o && timeout_flag_o;
  endproperty
  a_flags_entry: assert property (p_flags_entry) else $error("flags wrong on entry");

  property p_osc_off;
    in_sleep |-> !osc_en_o;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on in sleep");

  property p_io_hold;
    in_sleep && $past(in_sleep) |-> $stable(io_o);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("pins moved in sleep");

  property p_no_master_clear_pin_drive;
    wdt_reset |=> core_reset_o && master_clear_pin_oe_n_o;
  endproperty
  a_no_master_clear_pin_drive: assert property (p_no_master_clear_pin_drive) else $error("wdt reset wrong");

  property p_master_clear_pin_wake;
    in_sleep && !master_clear_pin_m2_r |=> core_reset_o && in_run && !resume_o;
  endproperty
  a_master_clear_pin_wake: assert property (p_master_clear_pin_wake) else $error("master_clear_pin wake did not reset");

  property p_to_clear;
    in_sleep && wdt_to && master_clear_pin_m2_r |=> !timeout_flag_o;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout_flag kept on wdt wake");

  property p_nop;
    in_run && sleep_exec_i && wake_req |=> in_run && sleep_nop_o && $stable(pd_r) && $stable(to_r);
  endproperty
  a_nop: assert property (p_nop) else $error("pending irq sleep not a no-op");

  property p_prefetch;
    in_run && sleep_exec_i |=> prefetch_addr_o == $past(pc_i) + `PC_W'(1);
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong");

  property p_fast_resume;
    s_irq_wake_fast |=> resume_o && (vector_o == global_irq_enable) && wdt_cnt_r == '0;
  endproperty
  a_fast_resume: assert property (p_fast_resume) else $error("irq wake resume wrong");

  property p_ost_hold;
    in_ost |-> wdt_cnt_r == '0;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("watchdog runs during start-up");

  property p_ost_quiet;
    in_ost |-> !resume_o;
  endproperty
  a_ost_quiet: assert property (p_ost_quiet) else $error("resume during start-up");

  // a master clear during start-up ends it without resume, so it is left out here
  property p_ost_wait;
    $fell(in_ost) && !core_reset_o |-> resume_o && (ost_span_r == OST_SPAN);
  endproperty
  a_ost_wait: assert property (p_ost_wait) else $error("start-up delay wrong");
endmodule

// File: verif/core_model.sv
// behavioural core side: program counter and pin drive requests
`timescale 1ns/1ps
`include "sleep_wake_cfg.svh"
module core_model
  import sleep_wake_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_en_i,
  output logic [`PC_W-1:0] pc_o,
  output io_drive_t io_o
);
  // pc stops with the oscillator; pin requests keep moving so a leaky hold shows
  always @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 13'h0010;
      io_o <= 16'h0000;
    end else begin
      io_o <= io_o + 16'h0123;
      if (osc_en_i) begin
        pc_o <= pc_o + 13'h0001;
      end
    end
  end
endmodule

// File: verif/sleep_wake_controller_tb.sv
// self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
`include "sleep_wake_cfg.svh"
module sleep_wake_controller_tb
  import sleep_wake_pkg::*;
;
  localparam int WDT = 64;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_exec_i = 1'b0;
  logic watchdog_clear_instr_i = 1'b0;
  logic master_clear_pin_n_i = 1'b1;
  logic [`ADDR_W-1:0] addr_i = '0;
  logic [`DATA_W-1:0] wdata_i = '0;
  logic [`DATA_W-1:0] rdata_o;
  logic [`IRQ_SRCS-1:0] irq_flags_i = '0;
  logic [`PC_W-1:0] pc_i, pc_s, prefetch_addr_o, vector_addr_o;
  io_drive_t io_i, io_o, io_held;
  logic master_clear_pin_oe_n_o, osc_en_o, core_reset_o, resume_o, vector_o, sleep_nop_o;
  logic power_down_flag_o, timeout_flag_o;
  int n_mismatch = 0;
  int checks = 0;

  sleep_wake_controller #(.WDT_CYCLES(WDT)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sleep_exec_i(sleep_exec_i), .watchdog_clear_instr_i(watchdog_clear_instr_i), .pc_i(pc_i),
    .irq_flags_i(irq_flags_i), .master_clear_pin_n_i(master_clear_pin_n_i), .master_clear_pin_oe_n_o(master_clear_pin_oe_n_o),
    .io_i(io_i), .io_o(io_o), .osc_en_o(osc_en_o), .core_reset_o(core_reset_o),
    .resume_o(resume_o), .vector_o(vector_o), .sleep_nop_o(sleep_nop_o),
    .prefetch_addr_o(prefetch_addr_o), .vector_addr_o(vector_addr_o),
    .power_down_flag_o(power_down_flag_o), .timeout_flag_o(timeout_flag_o));
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .osc_en_i(osc_en_o), .pc_o(pc_i),
    .io_o(io_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, e, "read data");
  endtask

  task automatic do_sleep();
    @(posedge clk_i);
    sleep_exec_i <= 1'b1;
    @(posedge clk_i);
    pc_s = pc_i;
    sleep_exec_i <= 1'b0;
    #1;
  endtask

  task automatic waitfor(input bit rst, output int n);
    n = 0;
    while ((rst ? core_reset_o : resume_o) !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_reset();
    chk(power_down_flag_o, 1'b1, "pd");
    chk(master_clear_pin_oe_n_o, 1'b1, "master_clear_pin drive");
    chk(vector_addr_o, `IRQ_VECTOR, "vector");
    rdchk(`REG_STATUS, 8'h7F, 8'h03);
    rdchk(4'h7, 8'hFF, 8'h00);
    wr(`REG_IRQ_EN, 8'h01);
    @(posedge clk_i);
    irq_flags_i <= 7'h01;
    do_sleep();
    chk(sleep_nop_o, 1'b1, "nop");
    chk(power_down_flag_o, 1'b1, "pd kept");
    chk(osc_en_o, 1'b1, "osc kept");
    @(posedge clk_i);
    irq_flags_i <= 7'h00;
    $display("reset and no-op test done");
  endtask

  task automatic t_irq();
    int n;
    logic [2:0] md;
    for (int s = 0; s < 7; s++) begin
      md = (s == 6) ? 3'd3 : 3'(s);
      // watchdog on: a start-up count that leaks into it would time out
      wr(`REG_CTRL, {3'b000, md, s[0], 1'b1});
      wr(`REG_IRQ_EN, 8'(1 << s));
      do_sleep();
      chk(osc_en_o, 1'b0, "osc off");
      chk(power_down_flag_o, 1'b0, "pd");
      chk(timeout_flag_o, 1'b1, "to");
      chk(prefetch_addr_o, pc_s + 13'h0001, "prefetch");
      io_held = io_o;
      @(posedge clk_i);
      irq_flags_i <= ~(7'(1 << s));
      cyc(4);
      chk(io_o, io_held, "pins held");
      chk(resume_o, 1'b0, "disabled woke");
      rdchk(`REG_STATUS, 8'h0F, 8'h06);
      @(posedge clk_i);
      irq_flags_i <= 7'h7F;
      waitfor(1'b0, n);
      chk(s < 3 ? (n > 1024 && n < 1027) : n == 1, 1'b1, "wake delay");
      chk(vector_o, s[0], "vector");
      chk(timeout_flag_o, 1'b1, "held wdt");
      if (s < 3) begin
        waitfor(1'b1, n);
        chk(n >= WDT - 3 && n <= WDT + 2, 1'b1, "wdt after start-up");
      end
      @(posedge clk_i);
      irq_flags_i <= 7'h00;
    end
    $display("interrupt wake test done");
  endtask

  task automatic t_late();
    int n;
    wr(`REG_CTRL, 8'h0C);
    wr(`REG_IRQ_EN, 8'h40);
    @(posedge clk_i);
    sleep_exec_i <= 1'b1;
    @(posedge clk_i);
    sleep_exec_i <= 1'b0;
    irq_flags_i <= 7'h40;
    waitfor(1'b0, n);
    chk(n <= 3, 1'b1, "late wake");
    chk(power_down_flag_o, 1'b0, "pd");
    @(posedge clk_i);
    irq_flags_i <= 7'h00;
    $display("late interrupt test done");
  endtask

  task automatic t_wdt();
    int n;
    wr(`REG_CTRL, 8'h0D);
    wr(`REG_IRQ_EN, 8'h00);
    @(posedge clk_i);
    watchdog_clear_instr_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_instr_i <= 1'b0;
    do_sleep();
    waitfor(1'b0, n);
    chk(n >= WDT - 3 && n <= WDT + 2, 1'b1, "wdt wake time");
    chk(timeout_flag_o, 1'b0, "to");
    chk(core_reset_o, 1'b0, "no reset");
    waitfor(1'b1, n);
    chk(n >= WDT - 3 && n <= WDT + 2, 1'b1, "count after wake");
    chk(master_clear_pin_oe_n_o, 1'b1, "master_clear_pin drive");
    rdchk(`REG_STATUS, 8'h7F, 8'h20);
    wr(`REG_CTRL, 8'h0C);
    $display("watchdog test done");
  endtask

  // clock enable low must stop the sleeping watchdog, so the wake comes late
  task automatic t_freeze();
    int n;
    wr(`REG_CTRL, 8'h0D);
    do_sleep();
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    chk(osc_en_o, 1'b0, "frozen sleep");
    waitfor(1'b0, n);
    chk(n >= WDT - 3 && n <= WDT + 2, 1'b1, "frozen wdt");
    wr(`REG_CTRL, 8'h0C);
    $display("clock enable test done");
  endtask

  task automatic t_master_clear_pin();
    int n;
    do_sleep();
    @(posedge clk_i);
    master_clear_pin_n_i <= 1'b0;
    waitfor(1'b1, n);
    chk(n <= 3, 1'b1, "reset");
    chk(resume_o, 1'b0, "resume");
    rdchk(`REG_STATUS, 8'h7C, 8'h10);
    chk(power_down_flag_o, 1'b0, "pd");
    @(posedge clk_i);
    master_clear_pin_n_i <= 1'b1;
    cyc(4);
    $display("master clear test done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_irq();
    t_late();
    t_wdt();
    t_freeze();
    t_master_clear_pin();
    stop_test();
  end

  // the whole run needs about 3700 cycles
  initial begin
    #(25 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule
